// File: hdl/link_rcrb_pkg.sv
// Purpose: Constants for the serial link root complex register block.
// Assumes: Byte offsets within the 4 KiB window, 32-bit word accesses.
// Notes:   Link control shares a word with link status; each VC status register sits alone in the upper half of its word.
package link_rcrb_pkg;

  // ---------------------------------------------------------------------
  // Window geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 3;
  localparam int CTL_W = 16;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_VC_CAP_HDR    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_PORT_VC_CAP1  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_VC0_RES_CAP   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_VC0_RES_CTL   = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_VC0_RES_STS   = 12'h01A;
  localparam logic [ADDR_W-1:0] OFF_VC1_RES_CAP   = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_VC1_RES_CTL   = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_VC1_RES_STS   = 12'h026;
  localparam logic [ADDR_W-1:0] OFF_LINK_DECL_HDR = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_ELEM_SELF     = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_LE1_DESC      = 12'h050;
  localparam logic [ADDR_W-1:0] OFF_LE1_ADDR      = 12'h058;
  localparam logic [ADDR_W-1:0] OFF_LE2_DESC      = 12'h060;
  localparam logic [ADDR_W-1:0] OFF_LE2_ADDR      = 12'h068;
  localparam logic [ADDR_W-1:0] OFF_LINK_CAP      = 12'h084;
  localparam logic [ADDR_W-1:0] OFF_LINK_CTL      = 12'h088;
  localparam logic [ADDR_W-1:0] OFF_LINK_STS      = 12'h08A;

  // ---------------------------------------------------------------------
  // Reserved words inside the window
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_RSV_A_FIRST   = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_RSV_A_LAST    = 12'h03C;
  localparam logic [ADDR_W-1:0] OFF_RSV_DECL_LO   = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_RSV_DECL_HI   = 12'h04C;
  localparam logic [ADDR_W-1:0] OFF_RSV_LE1_PAD   = 12'h054;
  localparam logic [ADDR_W-1:0] OFF_RSV_LE2_PAD   = 12'h064;
  localparam logic [ADDR_W-1:0] OFF_RSV_B_FIRST   = 12'h070;
  localparam logic [ADDR_W-1:0] OFF_RSV_B_LAST    = 12'h080;

  // ---------------------------------------------------------------------
  // Header fields and reset values
  // ---------------------------------------------------------------------
  localparam logic [11:0] NEXT_CAP_PTR    = 12'h040;
  localparam logic [3:0]  VC_CAP_VERSION  = 4'h1;
  localparam logic [15:0] EXT_CAP_ID      = 16'h0002;
  localparam logic [2:0]  LP_EXTRA_COUNT  = 3'h0;
  localparam logic [2:0]  EXT_COUNT_RESET = 3'h1;

  localparam logic [31:0] RST_VC0_RES_CAP   = 32'h00000001;
  localparam logic [31:0] RST_VC0_RES_CTL   = 32'h800000FF;
  localparam logic [15:0] RST_VC0_RES_STS   = 16'h0002;
  localparam logic [31:0] RST_VC1_RES_CAP   = 32'h00008001;
  localparam logic [31:0] RST_VC1_RES_CTL   = 32'h01000000;
  localparam logic [15:0] RST_VC1_RES_STS   = 16'h0002;
  localparam logic [31:0] RST_LINK_DECL_HDR = 32'h08010005;
  localparam logic [31:0] RST_ELEM_SELF     = 32'h01000202;
  localparam logic [31:0] RST_LINK_CAP      = 32'h00012C41;
  localparam logic [15:0] RST_LINK_CTL      = 16'h0000;
  localparam logic [15:0] RST_LINK_STS      = 16'h0001;

endpackage

// File: hdl/link_rcrb_regs.sv
// Purpose: Register block behind the link register base window.
// Assumes: One access per cycle; a read answers on the next edge.
// Notes:   Sixteen-bit registers live in the half of their word.
`timescale 1ns/1ps
`default_nettype none

module link_rcrb_regs (
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 arst_n,
  // Memory-mapped access from the base window
  input  wire logic                                 req_valid,
  input  wire logic                                 req_write,
  input  wire logic [link_rcrb_pkg::ADDR_W-1:0]     req_addr,
  input  wire logic [3:0]                           req_be,
  input  wire logic [link_rcrb_pkg::DATA_W-1:0]     req_wdata,
  output logic                                      rsp_valid,
  output logic      [link_rcrb_pkg::DATA_W-1:0]     rsp_rdata,
  // Settings seen by the link logic
  output logic      [link_rcrb_pkg::COUNT_W-1:0]    extended_channel_count,
  output logic      [link_rcrb_pkg::CTL_W-1:0]      link_control
);
  import link_rcrb_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic [COUNT_W-1:0] ext_count_r, ext_count_nxt;
  logic               ext_locked_r, ext_locked_nxt;
  logic [CTL_W-1:0]   link_ctl_r, link_ctl_nxt;
  logic               rsp_valid_r, rsp_valid_nxt;
  logic [DATA_W-1:0]  rdata_r, rdata_nxt;
  logic [ADDR_W-1:0]  word_addr;
  logic               cnt_take;
  logic [CTL_W/8-1:0] lctl_lane_we;

  // The two low address bits are dropped, so every access is a whole word.
  // A sixteen-bit register is reached through the word that holds it.
  assign word_addr = {req_addr[ADDR_W-1:2], 2'b00};

  // ---------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------
  // Unmapped and reserved words read as zero.
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0]  a,
    input logic [COUNT_W-1:0] cnt,
    input logic [CTL_W-1:0]   lctl
  );
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      OFF_VC_CAP_HDR:   v = {NEXT_CAP_PTR, VC_CAP_VERSION, EXT_CAP_ID};
      OFF_PORT_VC_CAP1: v = {25'h0000000, LP_EXTRA_COUNT, 1'b0, cnt};
      OFF_VC0_RES_CAP:  v = RST_VC0_RES_CAP;
      OFF_VC0_RES_CTL:  v = RST_VC0_RES_CTL;
      (OFF_VC0_RES_STS & 12'hFFC): v = {RST_VC0_RES_STS, 16'h0000};
      OFF_VC1_RES_CAP:  v = RST_VC1_RES_CAP;
      OFF_VC1_RES_CTL:  v = RST_VC1_RES_CTL;
      (OFF_VC1_RES_STS & 12'hFFC): v = {RST_VC1_RES_STS, 16'h0000};
      OFF_LINK_DECL_HDR: v = RST_LINK_DECL_HDR;
      OFF_ELEM_SELF:    v = RST_ELEM_SELF;
      OFF_LINK_CAP:     v = RST_LINK_CAP;
      OFF_LINK_CTL:     v = {RST_LINK_STS, lctl};
      default:          v = '0;
    endcase
    return v;
  endfunction

  // Words that the map leaves reserved; each must read as zero.
  // Halves of shared words are not listed: those words carry status.
  function automatic logic reserved_word(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      OFF_RSV_DECL_LO, OFF_RSV_DECL_HI: hit = 1'b1;
      OFF_RSV_LE1_PAD, OFF_RSV_LE2_PAD: hit = 1'b1;
      default: hit = (a >= OFF_RSV_A_FIRST && a <= OFF_RSV_A_LAST)
                     || (a >= OFF_RSV_B_FIRST && a <= OFF_RSV_B_LAST);
    endcase
    return hit;
  endfunction

  // ---------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------
  // Only a write carrying byte lane 0 consumes the one-time count write.
  assign cnt_take = req_valid && req_write && word_addr == OFF_PORT_VC_CAP1
                    && req_be[0] && !ext_locked_r;

  // Link control has two byte lanes with identical write logic.
  for (genvar g = 0; g < CTL_W / 8; g++) begin : g_lctl_lane
    assign lctl_lane_we[g] = req_valid && req_write
                             && word_addr == OFF_LINK_CTL && req_be[g];
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // A read answers one edge later; the word then holds until the next read,
  // so a host that looks late still sees the last answer.
  always_comb begin
    ext_count_nxt  = ext_count_r;
    ext_locked_nxt = ext_locked_r;
    link_ctl_nxt   = link_ctl_r;
    rsp_valid_nxt  = req_valid && !req_write;
    rdata_nxt      = rdata_r;
    if (req_valid && !req_write) begin
      rdata_nxt = read_word(word_addr, ext_count_r, link_ctl_r);
    end
    // The count can be written once so firmware fixes it until the next reset.
    if (cnt_take) begin
      ext_count_nxt  = req_wdata[COUNT_W-1:0];
      ext_locked_nxt = 1'b1;
    end
    for (int k = 0; k < CTL_W / 8; k++) begin
      if (lctl_lane_we[k]) begin
        link_ctl_nxt[k*8 +: 8] = req_wdata[k*8 +: 8];
      end
    end
  end

  // Reset reopens the one-time write, so firmware must set the count again
  // after every reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_count_r  <= EXT_COUNT_RESET;
      ext_locked_r <= 1'b0;
      link_ctl_r   <= RST_LINK_CTL;
      rsp_valid_r  <= 1'b0;
      rdata_r      <= '0;
    end else begin
      ext_count_r  <= ext_count_nxt;
      ext_locked_r <= ext_locked_nxt;
      link_ctl_r   <= link_ctl_nxt;
      rsp_valid_r  <= rsp_valid_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign rsp_valid              = rsp_valid_r;
  assign rsp_rdata              = rdata_r;
  assign extended_channel_count = ext_count_r;
  assign link_control           = link_ctl_r;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence rd_at(logic [ADDR_W-1:0] a);
    req_valid && !req_write && word_addr == a;
  endsequence

  // Header fields are held against fixed values, and the port count against the
  // held count, one edge after the access, where the answer stands.
  AST_NEXT_PTR: assert property (rd_at(OFF_VC_CAP_HDR) |=>
    rsp_valid && rsp_rdata[31:20] == 12'h040)
    else $error("Next capability pointer wrong.");
  AST_VERSION: assert property (rd_at(OFF_VC_CAP_HDR) |=>
    rsp_rdata[19:16] == 4'h1)
    else $error("Capability version wrong.");
  AST_CAP_ID: assert property (rd_at(OFF_VC_CAP_HDR) |=>
    rsp_rdata[15:0] == 16'h0002)
    else $error("Capability identifier wrong.");
  AST_LP_COUNT: assert property (rd_at(OFF_PORT_VC_CAP1) |=>
    rsp_rdata[6:4] == 3'b000)
    else $error("Low priority count not zero.");
  AST_FIRST_WRITE: assert property (
    req_valid && req_write && word_addr == OFF_PORT_VC_CAP1 && req_be[0]
    && !ext_locked_r |=> extended_channel_count == $past(req_wdata[2:0]))
    else $error("First count write not taken.");
  AST_COUNT_READ: assert property (rd_at(OFF_PORT_VC_CAP1) |=>
    rsp_rdata[2:0] == $past(extended_channel_count))
    else $error("Reported count differs from held count.");
  AST_LOCKED: assert property (ext_locked_r |=>
    $stable(extended_channel_count) [*2])
    else $error("Count changed after first write.");
  AST_RESERVED: assert property (rd_at(OFF_PORT_VC_CAP1) |=>
    rsp_rdata[31:7] == '0 && !rsp_rdata[3])
    else $error("Reserved bits not zero.");
  AST_HDR_WORD: assert property (rd_at(OFF_VC_CAP_HDR) |=>
    rsp_rdata == 32'h04010002)
    else $error("Capability header word wrong.");
  AST_RESERVED_WORD: assert property (
    req_valid && !req_write && reserved_word(word_addr) |=> rsp_rdata == '0)
    else $error("Reserved word not zero.");

  // The one-time count sits at its reset value until the taking write,
  // moves only on that write, and the lock never drops before reset.
  AST_UNLOCKED_ONE: assert property (!ext_locked_r |->
    extended_channel_count == 3'h1)
    else $error("Count left its reset value before any write.");
  AST_UNLOCKED_READ: assert property (
    req_valid && !req_write && word_addr == OFF_PORT_VC_CAP1
    && !ext_locked_r |=> rsp_rdata[2:0] == 3'h1)
    else $error("Count read before any write is not one.");
  AST_COUNT_SOURCE: assert property (
    !$stable(extended_channel_count) |-> $past(cnt_take))
    else $error("Count changed without a taking write.");
  AST_LOCK_ON_TAKE: assert property (cnt_take |=> ext_locked_r)
    else $error("Count write did not close the one-time write.");
  AST_LOCK_STICKY: assert property (ext_locked_r |=> ext_locked_r)
    else $error("One-time write reopened without reset.");

  // ---------------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------------
  COV_HDR_READ: cover property (rd_at(OFF_VC_CAP_HDR) ##1 rsp_valid);
  COV_TWO_WRITES: cover property (
    req_valid && req_write && word_addr == OFF_PORT_VC_CAP1 ##[1:5]
    req_valid && req_write && word_addr == OFF_PORT_VC_CAP1);
  COV_LINK_CTL: cover property (link_control != 16'h0000);
  COV_RESERVED_READ: cover property (
    req_valid && !req_write && reserved_word(word_addr) ##1 rsp_valid);
  COV_LOCKED_WRITE: cover property (
    ext_locked_r && req_valid && req_write && word_addr == OFF_PORT_VC_CAP1);

endmodule

`default_nettype wire

// File: bench/host_bfm.sv
// Purpose: Host model that issues word accesses to the register window.
// Assumes: A request is taken on the rising edge that sees it valid.
// Notes:   Released address and data lines show inverted values so stale data never helps.
`timescale 1ns/1ps
`default_nettype none
module host_bfm (
  // Clock
  input  wire logic                             clk,
  // Request side
  output logic                                  req_valid,
  output logic                                  req_write,
  output logic [link_rcrb_pkg::ADDR_W-1:0]      req_addr,
  output logic [3:0]                            req_be,
  output logic [link_rcrb_pkg::DATA_W-1:0]      req_wdata,
  // Answer side
  input  wire logic                             rsp_valid,
  input  wire logic [link_rcrb_pkg::DATA_W-1:0] rsp_rdata
);
  import link_rcrb_pkg::*;
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = '0;
    req_be    = 4'h0;
    req_wdata = '0;
  end
  task automatic put(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [3:0] be, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    {req_valid, req_write, req_addr, req_be, req_wdata} = {1'b1, w, a, be, d};
    @(posedge clk);
    #1;
    {req_valid, req_write, req_addr, req_wdata} = {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    put(1'b0, a, 4'h0, '0);
    // The valid flag stands for one cycle only, so the answer is taken right here.
    d = (rsp_valid === 1'b1) ? rsp_rdata : 'x;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_link_rcrb_regs.sv
// Purpose: Self-checking bench for the link register block.
// Assumes: The host model drives every request input.
// Notes:   Expected words are the table values, built by hand.
`timescale 1ns/1ps
`default_nettype none
module tb_link_rcrb_regs;
  import link_rcrb_pkg::*;
  logic              clk, arst_n, req_valid, req_write, rsp_valid;
  logic [ADDR_W-1:0] req_addr;
  logic [3:0]        req_be;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, d;
  logic [2:0]        cnt;
  logic [15:0]       lctl;
  int                miscompares, n_tests, cyc, i;
  logic [11:0] ta [16] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h018,
    12'h01C, 12'h020, 12'h024, 12'h040, 12'h044, 12'h058, 12'h084, 12'h088,
    12'h100, 12'h030, 12'h04C};
  logic [31:0] td [16] = '{32'h04010002, 32'h00000001, 32'h00000001,
    32'h800000FF, 32'h00020000, 32'h00008001, 32'h01000000, 32'h00020000,
    32'h08010005, 32'h01000202, 32'h00000000, 32'h00012C41, 32'h00010000,
    32'h00000000, 32'h00000000, 32'h00000000};
  link_rcrb_regs i_dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_be(req_be),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .extended_channel_count(cnt), .link_control(lctl));
  host_bfm i_host (.clk(clk), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hung access ends the run well past the fewer than sixty cycles needed.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    {miscompares, n_tests, cyc} = '0;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("count", {29'h0, cnt}, 32'h1);
    chk("lctl", {16'h0, lctl}, 32'h0);
    for (i = 0; i < 16; i++) begin
      i_host.rd(ta[i], d);
      chk("reset word", d, td[i]);
    end
    $display("test reset values done");
    i_host.put(1'b1, 12'h000, 4'hF, 32'hFFFFFFFF);
    i_host.rd(12'h000, d);
    chk("header", d, 32'h04010002);
    i_host.put(1'b1, 12'h004, 4'hF, 32'hFFFFFF75);
    chk("count", {29'h0, cnt}, 32'h5);
    i_host.put(1'b1, 12'h004, 4'hF, 32'h00000003);
    i_host.rd(12'h004, d);
    chk("cap1", d, 32'h00000005);
    $display("test write once done");
    i_host.put(1'b1, 12'h088, 4'h3, 32'hFFFFA5C3);
    i_host.put(1'b1, 12'h088, 4'h1, 32'h000000FF);
    chk("lctl", {16'h0, lctl}, 32'h0000A5FF);
    i_host.rd(12'h088, d);
    chk("lword", d, 32'h0001A5FF);
    $display("test link control done");
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk("count", {29'h0, cnt}, 32'h1);
    i_host.put(1'b1, 12'h004, 4'h1, 32'h00000007);
    i_host.rd(12'h004, d);
    chk("cap1", d, 32'h00000007);
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
